// file: tfs_pkg.sv
// Purpose: Shared constants and types for the transmitter fault supervisor
// Assumes: 40 MHz system clock, all inputs synchronous to it
// Notes:   Long counts are derived here and used as top-level defaults
package tfs_pkg;
   // System clock
   localparam int CLK_HZ        = 40_000_000;
   localparam int CYC_PER_MS    = CLK_HZ / 1000;
   localparam int CYC_PER_US    = CLK_HZ / 1_000_000;

   // Times as printed, in their own units
   localparam int OFF_TIME_MS      = 1000;   // First timer
   localparam int REARM_TIME_MS    = 2400;   // Second timer
   localparam int STRETCH_TIME_MS  = 500;    // Reflect status stretcher
   localparam int LOWER_TIME_MS    = 47;     // Power-lower extension per hit
   localparam int HIT_GAP_TIME_MS  = 100;    // Max spacing inside a hit burst
   localparam int SWITCH_TIME_US   = 5;      // Drive switch-over pulse width

   // Derived cycle counts
   localparam int OFF_CYC     = OFF_TIME_MS * CYC_PER_MS;
   localparam int REARM_CYC   = REARM_TIME_MS * CYC_PER_MS;
   localparam int STRETCH_CYC = STRETCH_TIME_MS * CYC_PER_MS;
   localparam int LOWER_CYC   = LOWER_TIME_MS * CYC_PER_MS;
   localparam int HIT_GAP_CYC = HIT_GAP_TIME_MS * CYC_PER_MS;
   localparam int SWITCH_CYC  = SWITCH_TIME_US * CYC_PER_US;

   // Counter geometry
   localparam int CNT_W       = 27;
   localparam int HIT_W       = 5;
   localparam logic [HIT_W-1:0] HIT_THRESH = 5'h19;  // 25 hits in a burst
   localparam logic [CNT_W-1:0] CNT_ZERO   = 27'h0;
   localparam logic [CNT_W-1:0] CNT_ONE    = 27'h1;
   localparam logic [CNT_W-1:0] CNT_MAX    = 27'h7ffffff;
   localparam logic [HIT_W-1:0] HIT_ZERO   = 5'h0;
   localparam logic [HIT_W-1:0] HIT_ONE    = 5'h1;

   // Channel counts and indices
   localparam int NUM_CH   = 3;
   localparam int CH_OVER  = 0;
   localparam int CH_UNDER = 1;
   localparam int CH_SUPP  = 2;
   localparam int NUM_REFL = 2;
   localparam int REFL_BPF = 0;
   localparam int REFL_ANT = 1;

   // Bicolor indicator drive
   typedef struct packed {
      logic red;
      logic grn;
   } tfs_led_t;

   // Status phase of one fault channel
   typedef enum logic [1:0] {
      TFS_NORMAL,
      TFS_DETECT,
      TFS_WINDOW,
      TFS_REPEAT
   } tfs_phase_t;
endpackage

// file: tfs_top.sv
// Purpose: Fault supervision for a transmitter status board
// Assumes: Inputs synchronous to CLK_I; SRST_I synchronous, active high
// Notes:   Long one-shot times are top parameters so simulation can shorten them
//
// Overview of operation
// - Peak or average overload triggers supply channel
// - Average overload forwarded as power feedback
// - Three identical fault channels with timers
// - Fault rising edge starts one-second timer
// - First-timer pulses ORed into fault output
// - First timer end starts 2.4 s timer
// - Both timers active flags a repeated fault
// - Any repeated fault gives shutdown fault
// - Repeated fault sets the channel latch
// - Window expiry returns an unlatched channel to normal
// - Indicator shows green, amber, off, red
// - Simultaneous hits keep only antenna path
// - Any hit drives combined fault, amp off
// - Retriggerable 0.5 s reflect status stretchers
// - Stretchers held off during supply fault
// - Burst of hits latches reflect status
// - Repeated hits issue power-lower command
// - Class three only lowers power
// - Antenna input inverted to active-high pulse
// - Twenty-five rapid hits mean burst
// - Each further hit extends lower 47 ms
`timescale 1ns/1ps
module tfs_top #(
   parameter int OFF_CYC     = tfs_pkg::OFF_CYC,
   parameter int REARM_CYC   = tfs_pkg::REARM_CYC,
   parameter int STRETCH_CYC = tfs_pkg::STRETCH_CYC,
   parameter int LOWER_CYC   = tfs_pkg::LOWER_CYC,
   parameter int HIT_GAP_CYC = tfs_pkg::HIT_GAP_CYC
) (
   input  wire logic                                 CLK_I,
   input  wire logic                                 SRST_I,
   input  wire logic                                 OVERDRIVE_I,
   input  wire logic                                 UNDERDRIVE_I,
   input  wire logic                                 PEAK_OVL_I,
   input  wire logic                                 AVG_OVL_I,
   input  wire logic                                 BPF_REFLECT_N_I,
   input  wire logic                                 ANT_REFLECT_N_I,
   input  wire logic                                 SUPPLY_FAULT_N_I,
   input  wire logic                                 OVERTEMP_I,
   input  wire logic                                 STATUS_RESET_I,
   output logic                                      AVG_FEEDBACK_O,
   output logic                                      CLASS2_FAULT_O,
   output logic                                      CLASS1_FAULT_O,
   output tfs_pkg::tfs_led_t [tfs_pkg::NUM_CH-1:0]   CH_LED_O,
   output logic              [tfs_pkg::NUM_CH-1:0]   CH_EXT_O,
   output logic                                      REFLECT_FAULT_N_O,
   output logic                                      AMP_DISABLE_O,
   output logic                                      DRIVE_SWITCHOVER_PULSE_O,
   output tfs_pkg::tfs_led_t [tfs_pkg::NUM_REFL-1:0] REFL_LED_O,
   output logic              [tfs_pkg::NUM_REFL-1:0] REFL_EXT_O,
   output logic                                      REFLECT_POWER_LOWER_O,
   output logic                                      CLASS3_FAULT_O
);
   localparam int                         NCH = tfs_pkg::NUM_CH;
   localparam int                         NRF = tfs_pkg::NUM_REFL;
   localparam int                         CW  = tfs_pkg::CNT_W;
   localparam logic [CW-1:0]              OFF_LD     = CW'(OFF_CYC);
   localparam logic [CW-1:0]              REARM_LD   = CW'(REARM_CYC);
   localparam logic [CW-1:0]              STRETCH_LD = CW'(STRETCH_CYC);
   localparam logic [CW-1:0]              LOWER_LD   = CW'(LOWER_CYC);
   localparam logic [CW-1:0]              GAP_LD     = CW'(HIT_GAP_CYC);
   localparam logic [CW-1:0]              SWITCH_LD  = CW'(tfs_pkg::SWITCH_CYC);
   // Channel side signals
   logic [NCH-1:0]          ch_in;
   logic [NCH-1:0]          ch_in_reg;
   logic [NCH-1:0]          ch_rise;
   logic [CW-1:0]           t1_cnt_reg [NCH];
   logic [CW-1:0]           t2_cnt_reg [NCH];
   logic [NCH-1:0]          t1_act;
   logic [NCH-1:0]          t1_act_reg;
   logic [NCH-1:0]          t2_act;
   logic [NCH-1:0]          rpt;
   logic [NCH-1:0]          rpt_reg;
   logic [NCH-1:0]          ch_latch_reg;
   tfs_pkg::tfs_phase_t     phase [NCH];
   // Reflect side signals
   logic [NRF-1:0]          refl_act_reg;
   logic [NRF-1:0]          refl_prev_reg;
   logic [NRF-1:0]          refl_hit;
   logic [CW-1:0]           str_cnt_reg [NRF];
   logic [CW-1:0]           gap_cnt_reg [NRF];
   logic [tfs_pkg::HIT_W-1:0] hits_reg  [NRF];
   logic [NRF-1:0]          multi;
   logic [NRF-1:0]          refl_latch_reg;
   logic [CW-1:0]           lower_cnt_reg;
   logic [CW-1:0]           lower_next;
   logic [CW-1:0]           sw_cnt_reg;
   logic                    any_hit;
   logic                    lower_hit;
   // Counter decrement toward zero
   function automatic logic [CW-1:0] cnt_dec(input logic [CW-1:0] c);
      cnt_dec = (c == tfs_pkg::CNT_ZERO) ? tfs_pkg::CNT_ZERO : c - tfs_pkg::CNT_ONE;
   endfunction
   // Supply channel input and channel edges
   assign ch_in[tfs_pkg::CH_OVER]  = OVERDRIVE_I;
   assign ch_in[tfs_pkg::CH_UNDER] = UNDERDRIVE_I;
   assign ch_in[tfs_pkg::CH_SUPP]  = PEAK_OVL_I | AVG_OVL_I;
   assign ch_rise = ch_in & ~ch_in_reg;
   // Edge history of channel inputs, first-timer and repeat flags
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         ch_in_reg <= '0;
         t1_act_reg <= '0;
         rpt_reg <= '0;
      end else begin
         ch_in_reg <= ch_in;
         t1_act_reg <= t1_act;
         rpt_reg <= rpt;
      end
   end
   // Three identical second-class channels
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      assign t1_act[i] = t1_cnt_reg[i] != tfs_pkg::CNT_ZERO;
      assign t2_act[i] = t2_cnt_reg[i] != tfs_pkg::CNT_ZERO;
      assign rpt[i]    = t1_act[i] & t2_act[i];
      // First timer, one second off pulse
      always_ff @(posedge CLK_I) begin
         if (SRST_I) begin
            t1_cnt_reg[i] <= tfs_pkg::CNT_ZERO;
         end else if (ch_rise[i] && !t1_act[i]) begin
            t1_cnt_reg[i] <= OFF_LD;
         end else begin
            t1_cnt_reg[i] <= cnt_dec(t1_cnt_reg[i]);
         end
      end
      // Second timer, loaded in the last off cycle so the window has no gap
      always_ff @(posedge CLK_I) begin
         if (SRST_I) begin
            t2_cnt_reg[i] <= tfs_pkg::CNT_ZERO;
         end else if (t1_cnt_reg[i] == tfs_pkg::CNT_ONE) begin
            t2_cnt_reg[i] <= REARM_LD;
         end else begin
            t2_cnt_reg[i] <= cnt_dec(t2_cnt_reg[i]);
         end
      end
      // Fault latch, clocked by a repeated fault; set beats reset
      always_ff @(posedge CLK_I) begin
         if (SRST_I) begin
            ch_latch_reg[i] <= 1'b0;
         end else if (rpt[i] && !rpt_reg[i]) begin
            ch_latch_reg[i] <= 1'b1;
         end else if (STATUS_RESET_I) begin
            ch_latch_reg[i] <= 1'b0;
         end
      end
      // Indicator phase
      always_comb begin
         if (ch_latch_reg[i]) begin
            phase[i] = tfs_pkg::TFS_REPEAT;
         end else if (t1_act[i]) begin
            phase[i] = tfs_pkg::TFS_DETECT;
         end else if (t2_act[i]) begin
            phase[i] = tfs_pkg::TFS_WINDOW;
         end else begin
            phase[i] = tfs_pkg::TFS_NORMAL;
         end
      end
      // Bicolor and external status drive
      always_ff @(posedge CLK_I) begin
         if (SRST_I) begin
            CH_LED_O[i] <= '{red: 1'b0, grn: 1'b1};
            CH_EXT_O[i] <= 1'b0;
         end else begin
            case (phase[i])
               tfs_pkg::TFS_NORMAL: CH_LED_O[i] <= '{red: 1'b0, grn: 1'b1};
               tfs_pkg::TFS_DETECT: CH_LED_O[i] <= '{red: 1'b1, grn: 1'b1};
               tfs_pkg::TFS_WINDOW: CH_LED_O[i] <= '{red: 1'b0, grn: 1'b0};
               tfs_pkg::TFS_REPEAT: CH_LED_O[i] <= '{red: 1'b1, grn: 1'b0};
               default:             CH_LED_O[i] <= '{red: 1'b0, grn: 1'b1};
            endcase
            CH_EXT_O[i] <= ch_latch_reg[i] | t1_act[i];
         end
      end
   end

   // Channel level fault outputs
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         AVG_FEEDBACK_O <= 1'b0;
         CLASS2_FAULT_O <= 1'b0;
         CLASS1_FAULT_O <= 1'b0;
      end else begin
         AVG_FEEDBACK_O <= AVG_OVL_I;
         CLASS2_FAULT_O <= |t1_act;
         CLASS1_FAULT_O <= |rpt;
      end
   end

   // Reflect input stage: inhibit and matched delay in one register
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         refl_act_reg <= '0;
         refl_prev_reg <= '0;
      end else begin
         refl_act_reg[tfs_pkg::REFL_BPF] <= !BPF_REFLECT_N_I && ANT_REFLECT_N_I;
         refl_act_reg[tfs_pkg::REFL_ANT] <= !ANT_REFLECT_N_I;
         refl_prev_reg <= refl_act_reg;
      end
   end

   assign refl_hit  = refl_act_reg & ~refl_prev_reg;
   assign any_hit   = |refl_hit;
   assign lower_hit = |(refl_hit & refl_latch_reg);
   assign REFLECT_FAULT_N_O = ~(|refl_act_reg);
   assign AMP_DISABLE_O     = |refl_act_reg;

   // Per-path stretcher, burst counter and status latch
   for (genvar j = 0; j < NRF; j++) begin : g_refl
      assign multi[j] = (hits_reg[j] >= tfs_pkg::HIT_THRESH) &&  // Burst ends with the gap
                        (gap_cnt_reg[j] != tfs_pkg::CNT_ZERO);

      // Retriggerable 0.5 s stretcher
      always_ff @(posedge CLK_I) begin
         if (SRST_I || !SUPPLY_FAULT_N_I) begin
            str_cnt_reg[j] <= tfs_pkg::CNT_ZERO;
         end else if (refl_hit[j]) begin
            str_cnt_reg[j] <= STRETCH_LD;
         end else begin
            str_cnt_reg[j] <= cnt_dec(str_cnt_reg[j]);
         end
      end

      // Hit burst counter, restarts after a long gap
      always_ff @(posedge CLK_I) begin
         if (SRST_I) begin
            gap_cnt_reg[j] <= tfs_pkg::CNT_ZERO;
            hits_reg[j] <= tfs_pkg::HIT_ZERO;
         end else if (refl_hit[j]) begin
            gap_cnt_reg[j] <= GAP_LD;
            if (gap_cnt_reg[j] == tfs_pkg::CNT_ZERO) begin
               hits_reg[j] <= tfs_pkg::HIT_ONE;
            end else if (!multi[j]) begin
               hits_reg[j] <= hits_reg[j] + tfs_pkg::HIT_ONE;
            end
         end else begin
            gap_cnt_reg[j] <= cnt_dec(gap_cnt_reg[j]);
         end
      end

      // Repeated-hit status latch; set beats reset
      always_ff @(posedge CLK_I) begin
         if (SRST_I) begin
            refl_latch_reg[j] <= 1'b0;
         end else if (multi[j]) begin
            refl_latch_reg[j] <= 1'b1;
         end else if (STATUS_RESET_I) begin
            refl_latch_reg[j] <= 1'b0;
         end
      end

      // Reflect indicator drive
      always_ff @(posedge CLK_I) begin
         if (SRST_I) begin
            REFL_LED_O[j] <= '{red: 1'b0, grn: 1'b1};
            REFL_EXT_O[j] <= 1'b0;
         end else begin
            REFL_LED_O[j].red <= (str_cnt_reg[j] != tfs_pkg::CNT_ZERO) | refl_latch_reg[j];
            REFL_LED_O[j].grn <= (str_cnt_reg[j] == tfs_pkg::CNT_ZERO) & !refl_latch_reg[j];
            REFL_EXT_O[j] <= (str_cnt_reg[j] != tfs_pkg::CNT_ZERO) | refl_latch_reg[j];
         end
      end
   end

   // Power-lower extension, saturating
   always_comb begin
      lower_next = cnt_dec(lower_cnt_reg);
      if (lower_hit) begin
         lower_next = (lower_cnt_reg > tfs_pkg::CNT_MAX - LOWER_LD) ?
                      tfs_pkg::CNT_MAX : lower_cnt_reg + LOWER_LD;
      end
   end

   // Lower timer and drive switch-over one-shot
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         lower_cnt_reg <= tfs_pkg::CNT_ZERO;
         sw_cnt_reg <= tfs_pkg::CNT_ZERO;
      end else begin
         lower_cnt_reg <= lower_next;
         sw_cnt_reg <= any_hit ? SWITCH_LD : cnt_dec(sw_cnt_reg);
      end
   end

   // Power reduction outputs, never touching the amp supply
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         REFLECT_POWER_LOWER_O <= 1'b0;
         CLASS3_FAULT_O <= 1'b0;
         DRIVE_SWITCHOVER_PULSE_O <= 1'b0;
      end else begin
         REFLECT_POWER_LOWER_O <= lower_next != tfs_pkg::CNT_ZERO;
         CLASS3_FAULT_O <= (lower_next != tfs_pkg::CNT_ZERO) | OVERTEMP_I;
         DRIVE_SWITCHOVER_PULSE_O <= any_hit || sw_cnt_reg > tfs_pkg::CNT_ONE;
      end
   end
   // Checks
   sequence s_ch0_rise;
      ch_rise[0] && !t1_act[0];
   endsequence
   sequence s_ch0_off_end;
      t1_act_reg[0] && !t1_act[0];
   endsequence

   first_timer_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
      s_ch0_rise |=> t1_act[0] ##1 CLASS2_FAULT_O)
      else $error("first timer did not start on fault edge");
   second_timer_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
      s_ch0_off_end |-> t2_cnt_reg[0] == REARM_LD)
      else $error("second timer not loaded at end of off pulse");
   repeat_latch_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
      $rose(rpt[1]) |=> ch_latch_reg[1] && CLASS1_FAULT_O ##1 CH_LED_O[1] == 2'b10)
      else $error("repeated fault not latched");
   window_off_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
      (t2_act[1] && !t1_act[1] && !ch_latch_reg[1]) |=> CH_LED_O[1] == 2'b00)
      else $error("indicator not dark in rearm window");
   supply_or_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
      $rose(AVG_OVL_I) && !$past(PEAK_OVL_I) && !PEAK_OVL_I && !t1_act[2] |=> t1_act[2])
      else $error("average overload did not trigger supply channel");
   bpf_inhibit_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
      !BPF_REFLECT_N_I && !ANT_REFLECT_N_I |=> !refl_act_reg[0] && AMP_DISABLE_O)
      else $error("bandpass path not inhibited");
   switchover_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
      any_hit |=> DRIVE_SWITCHOVER_PULSE_O [*4])
      else $error("switch-over pulse too short");
   stretch_hold_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
      !SUPPLY_FAULT_N_I |=> str_cnt_reg[0] == tfs_pkg::CNT_ZERO &&
                            str_cnt_reg[1] == tfs_pkg::CNT_ZERO)
      else $error("stretcher not inhibited");
   lower_ext_a: assert property (@(posedge CLK_I) disable iff (SRST_I)
      lower_hit |=> REFLECT_POWER_LOWER_O && CLASS3_FAULT_O)
      else $error("power lower not issued on repeated hit");
endmodule

// file: tfs_far_model.sv
// Purpose: Behavioural far-side model giving active-low reflect pulses
// Assumes: Fire requests are sampled on the falling clock edge
// Notes:   Pulse lengths are shortened for simulation
`timescale 1ns/1ps
module tfs_far_model #(
   parameter int BPF_LEN = 6,
   parameter int ANT_LEN = 8
) (
   input  wire logic clk_i,
   input  wire logic fire_bpf_i,
   input  wire logic fire_ant_i,
   output logic      bpf_n_o,
   output logic      ant_n_o
);
   int bpf_cnt_reg = 0;
   int ant_cnt_reg = 0;

   // Pulse length counters, restarted by each request
   always @(negedge clk_i) begin
      if (fire_bpf_i) bpf_cnt_reg <= BPF_LEN;
      else if (bpf_cnt_reg != 0) bpf_cnt_reg <= bpf_cnt_reg - 1;
      if (fire_ant_i) ant_cnt_reg <= ANT_LEN;
      else if (ant_cnt_reg != 0) ant_cnt_reg <= ant_cnt_reg - 1;
   end

   // Lines rest high between pulses
   assign bpf_n_o = (bpf_cnt_reg == 0);
   assign ant_n_o = (ant_cnt_reg == 0);
endmodule

// file: tb_top.sv
// Purpose: Self-checking bench for the transmitter fault supervisor
// Assumes: Shortened timer parameters, inputs driven on the falling edge
// Notes:   Random pulse widths and hit spacing from a fixed seed
`timescale 1ns/1ps
module tb_top;
   localparam int OFF   = 20;
   localparam int REARM = 40;
   localparam int STR   = 30;
   localparam int LOW   = 10;
   localparam int GAP   = 50;
   logic                               clk    = 1'b0;
   logic                               srst   = 1'b1;
   logic                               ovd    = 1'b0;
   logic                               und    = 1'b0;
   logic                               pk     = 1'b0;
   logic                               av     = 1'b0;
   logic                               sup_n  = 1'b1;
   logic                               hot    = 1'b0;
   logic                               st_rst = 1'b0;
   logic                               f_bpf  = 1'b0;
   logic                               f_ant  = 1'b0;
   logic                               bpf_n;
   logic                               ant_n;
   logic                               avg_fb;
   logic                               c2;
   logic                               c1;
   logic                               rf_n;
   logic                               amp;
   logic                               swo;
   logic                               lower;
   logic                               c3;
   tfs_pkg::tfs_led_t [2:0]            ch_led;
   logic [2:0]                         ch_ext;
   tfs_pkg::tfs_led_t [1:0]            rf_led;
   logic [1:0]                         rf_ext;
   int                                 seed       = 29;
   int                                 errors     = 0;
   int                                 n_compared = 0;

   // Free-running 40 MHz clock
   always #12.5 clk = ~clk;

   tfs_top #(.OFF_CYC(OFF), .REARM_CYC(REARM), .STRETCH_CYC(STR), .LOWER_CYC(LOW),
             .HIT_GAP_CYC(GAP)) u_dut (
      .CLK_I(clk), .SRST_I(srst), .OVERDRIVE_I(ovd), .UNDERDRIVE_I(und),
      .PEAK_OVL_I(pk), .AVG_OVL_I(av), .BPF_REFLECT_N_I(bpf_n), .ANT_REFLECT_N_I(ant_n),
      .SUPPLY_FAULT_N_I(sup_n), .OVERTEMP_I(hot), .STATUS_RESET_I(st_rst),
      .AVG_FEEDBACK_O(avg_fb), .CLASS2_FAULT_O(c2), .CLASS1_FAULT_O(c1),
      .CH_LED_O(ch_led), .CH_EXT_O(ch_ext), .REFLECT_FAULT_N_O(rf_n),
      .AMP_DISABLE_O(amp), .DRIVE_SWITCHOVER_PULSE_O(swo), .REFL_LED_O(rf_led),
      .REFL_EXT_O(rf_ext), .REFLECT_POWER_LOWER_O(lower), .CLASS3_FAULT_O(c3));

   tfs_far_model #(.BPF_LEN(6), .ANT_LEN(8)) u_far (
      .clk_i(clk), .fire_bpf_i(f_bpf), .fire_ant_i(f_ant), .bpf_n_o(bpf_n), .ant_n_o(ant_n));

   // Compare one value, count it, report a difference
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic complete_run();
      if (errors == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Raise one channel input for a random width, four falling edges in all
   task automatic fire_ch(input int ch);
      int w;
      w = 1 + ($random(seed) & 3);
      case (ch)
         0: ovd = 1'b1;
         1: und = 1'b1;
         2: av = 1'b1;
         default: pk = 1'b1;
      endcase
      @(negedge clk);
      if (av) chk("avg_fb", avg_fb, 8'h1);
      idle(w - 1);
      {ovd, und, pk, av} = 4'h0;
      idle(4 - w);
   endtask

   // Ask the far side for reflect pulses; line is low one edge before return
   task automatic hit(input logic b, input logic a);
      f_bpf <= b;
      f_ant <= a;
      @(negedge clk);
      f_bpf <= 1'b0;
      f_ant <= 1'b0;
      @(negedge clk);
   endtask

   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      complete_run();
   end

   // Main sequence
   initial begin
      idle(16);
      chk("led_rst", ch_led, 8'h15);
      chk("rf_n_rst", rf_n, 8'h1);
      srst = 1'b0;
      idle(2);
      for (int ch = 0; ch < 4; ch++) begin
         fire_ch(ch);
         chk("c2_on", c2, 8'h1);
         chk("led_amber", ch_led[(ch > 2) ? 2 : ch], 8'h3);
         chk("ext_on", ch_ext[(ch > 2) ? 2 : ch], 8'h1);
         idle(26);
         chk("led_off", ch_led[(ch > 2) ? 2 : ch], 8'h0);
         chk("c2_off", c2, 8'h0);
         idle(45);
         chk("led_norm", ch_led[(ch > 2) ? 2 : ch], 8'h1);
         chk("c1_none", c1, 8'h0);
      end
      fire_ch(1);
      idle(26);
      fire_ch(1);
      chk("c1_rep", c1, 8'h1);
      idle(120);
      chk("led_red", ch_led[1], 8'h2);
      chk("ext_latch", ch_ext[1], 8'h1);
      st_rst = 1'b1;
      idle(1);
      st_rst = 1'b0;
      idle(3);
      chk("led_clr", ch_led[1], 8'h1);
      fire_ch(0);
      srst = 1'b1;
      idle(2);
      chk("c2_srst", c2, 8'h0);
      chk("led_srst", ch_led, 8'h15);
      srst = 1'b0;
      idle(2);
      hit(1'b0, 1'b1);
      idle(2);
      chk("amp_ant", amp, 8'h1);
      chk("rf_n_ant", rf_n, 8'h0);
      idle(3);
      chk("swo_on", swo, 8'h1);
      chk("red_ant", {rf_led[1].red, rf_ext[1], rf_led[0].red}, 8'h6);
      idle(15);
      hit(1'b0, 1'b1);
      idle(20);
      chk("red_ext", rf_led[1].red, 8'h1);
      idle(240);
      chk("quiet", {swo, amp, rf_led[1].red, rf_ext[1], rf_led[1].grn}, 8'h1);
      hit(1'b1, 1'b1);
      idle(5);
      chk("both_hit", {rf_led[1].red, rf_led[0].red}, 8'h2);
      idle(100);
      hit(1'b1, 1'b0);
      idle(5);
      chk("bpf_hit", {amp, rf_led[0].red, rf_ext[0]}, 8'h7);
      idle(100);
      sup_n = 1'b0;
      hit(1'b0, 1'b1);
      idle(5);
      chk("inhib", {amp, rf_led[1].red}, 8'h2);
      sup_n = 1'b1;
      idle(100);
      for (int i = 0; i < 26; i++) begin
         hit(1'b0, 1'b1);
         idle(8 + ($random(seed) & 15));
      end
      hit(1'b0, 1'b1);
      idle(4);
      chk("lower_on", {lower, c3, c2}, 8'h6);
      idle(150);
      chk("latched", {lower, c3, rf_led[1].red, rf_led[0].red}, 8'h2);
      st_rst = 1'b1;
      idle(1);
      st_rst = 1'b0;
      idle(3);
      chk("unlatch", rf_led[1].red, 8'h0);
      hot = 1'b1;
      idle(3);
      chk("hot", {c3, c2}, 8'h2);
      hot = 1'b0;
      idle(3);
      complete_run();
   end
endmodule
